// file: bit_fifo.v
/*
  small synchronous fifo with valid/ready on both sides.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module bit_fifo #(
  parameter WIDTH  = 1,
  parameter DEPTH  = 4,
  parameter ADDR_W = 2
) (
  input  wire             ref_clk,
  input  wire             sys_rst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);

  // ----------------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------------
  reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg  [ADDR_W:0]  wr_ptr_q;
  reg  [ADDR_W:0]  rd_ptr_q;
  wire             full;
  wire             empty;
  wire             push;
  wire             pop;

  assign empty     = (wr_ptr_q == rd_ptr_q);
  assign full      = (wr_ptr_q[ADDR_W] != rd_ptr_q[ADDR_W]) &&
                     (wr_ptr_q[ADDR_W-1:0] == rd_ptr_q[ADDR_W-1:0]);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem_q[rd_ptr_q[ADDR_W-1:0]];
  assign push      = in_valid & ~full;
  assign pop       = out_ready & ~empty;

  always @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_ptr_q[ADDR_W-1:0]] <= in_data;
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_ptr_q <= {(ADDR_W+1){1'b0}};
      rd_ptr_q <= {(ADDR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + {{ADDR_W{1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + {{ADDR_W{1'b0}}, 1'b1};
      end
    end
  end

endmodule // bit_fifo

`default_nettype wire

// file: panel_ctrl.sv
/* display controller model: shifts one 64-bit word into the driver.
   assumes start is a one-cycle pulse while busy is low. */
`timescale 1ns/1ps
`default_nettype none
module panel_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        start,
  input  wire logic        dir,
  input  wire logic        slow,
  input  wire logic [63:0] word,
  output var  logic        shift_clk = 1'b0,
  output var  logic        data_a    = 1'b0,
  output var  logic        data_b    = 1'b0,
  output var  logic        busy      = 1'b0
);
  int k  = 0;
  int ph = 0;
  always @(posedge ref_clk) begin
    if (!busy) begin
      busy <= start;
      k    <= 0;
      ph   <= 0;
      data_a <= ~data_a;
      data_b <= ~data_b;
    end else begin
      ph <= (ph == (slow ? 9 : 5)) ? 0 : ph + 1;
      // clock high 3 cycles, data set one cycle before it rises
      shift_clk <= (ph >= 1 && ph <= 3);
      if (ph == 0) begin
        if (dir) data_a <= word[63-k];
        else data_b <= word[k];
      end
      if (dir) data_b <= ~data_b;
      else data_a <= ~data_a;
      if (ph == (slow ? 9 : 5)) begin
        k    <= k + 1;
        busy <= (k != 63);
      end
    end
  end
endmodule // panel_ctrl
`default_nettype wire

// file: sipo_driver.v
/*
  64-stage serial to parallel driver: bidirectional shift register,
  64 transparent latches, polarity and blanking on the parallel outputs.
  assumes all pin inputs are asynchronous to ref_clk and are sampled by
  two flip-flops; the shift clock is slower than half of ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sipo_driver_map.vh"

// Behaviour
// - 64 shift stages, 64 latches, polarity and blanking on every output
// - each shift clock rising edge moves stages and loads entry stage
// - direction low shifts counter-clockwise, high shifts clockwise
// - high: enter at port a, n to n+1; low: enter at b, n to n-1
// - cascade port always shows the final stage
// - latch, blanking and polarity never affect shifting
// - latch enable high makes each latch follow its stage
// - latch enable low holds the latch value
// - blanking low forces all outputs to inverse of polarity
// - blanking high: outputs equal latch, inverted when polarity low
// - output 1 comes from the entry stage, rest in stage order
// - logical output numbering reverses with direction
module sipo_driver (
  input  wire                      ref_clk,
  input  wire                      sys_rst,
  input  wire                      shift_clk,
  input  wire                      shift_dir,
  input  wire                      latch_transparent,
  input  wire                      output_blank_n,
  input  wire                      output_polarity,
  input  wire                      serial_port_a_in,
  output reg                       serial_port_a_out,
  output reg                       serial_port_a_oe,
  input  wire                      serial_port_b_in,
  output reg                       serial_port_b_out,
  output reg                       serial_port_b_oe,
  output reg  [`STAGE_COUNT-1:0]   parallel_output,
  output wire                      capture_ready
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  reg  [1:0] clk_sync_q;
  reg        clk_prev_q;
  reg  [1:0] dir_sync_q;
  reg  [1:0] le_sync_q;
  reg  [1:0] bl_sync_q;
  reg  [1:0] pol_sync_q;
  reg  [1:0] a_sync_q;
  reg  [1:0] b_sync_q;
  reg        data_prev_q;
  wire       clk_rise;
  wire       entry_bit;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      clk_sync_q  <= 2'h0;
      clk_prev_q  <= 1'b0;
      dir_sync_q  <= 2'h0;
      le_sync_q   <= 2'h0;
      bl_sync_q   <= 2'h0;
      pol_sync_q  <= 2'h0;
      a_sync_q    <= 2'h0;
      b_sync_q    <= 2'h0;
      data_prev_q <= 1'b0;
    end else begin
      clk_sync_q  <= {clk_sync_q[0], shift_clk};
      clk_prev_q  <= clk_sync_q[1];
      dir_sync_q  <= {dir_sync_q[0], shift_dir};
      le_sync_q   <= {le_sync_q[0], latch_transparent};
      bl_sync_q   <= {bl_sync_q[0], output_blank_n};
      pol_sync_q  <= {pol_sync_q[0], output_polarity};
      a_sync_q    <= {a_sync_q[0], serial_port_a_in};
      b_sync_q    <= {b_sync_q[0], serial_port_b_in};
      data_prev_q <= entry_bit;
    end
  end

  // data taken from the sample before the clock was seen high
  assign entry_bit = dir_sync_q[1] ? a_sync_q[1] : b_sync_q[1];
  assign clk_rise  = clk_sync_q[1] & ~clk_prev_q;

  // ----------------------------------------------------------------------
  // capture fifo
  // ----------------------------------------------------------------------
  wire       fifo_out_bit;
  wire       fifo_out_valid;

  bit_fifo #(
    .WIDTH  (`FIFO_WIDTH),
    .DEPTH  (`FIFO_DEPTH),
    .ADDR_W (`FIFO_ADDR_W)
  ) u_capture_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_data   (data_prev_q),
    .in_valid  (clk_rise),
    .in_ready  (capture_ready),
    .out_data  (fifo_out_bit),
    .out_valid (fifo_out_valid),
    .out_ready (1'b1)
  );

  // ----------------------------------------------------------------------
  // shift register
  // ----------------------------------------------------------------------
  reg  [`STAGE_COUNT-1:0] stage_q;
  reg  [`STAGE_COUNT-1:0] stage_d;

  // only the shift clock and direction steer this path
  always @* begin
    stage_d = stage_q;
    if (fifo_out_valid) begin
      if (dir_sync_q[1]) begin
        stage_d = {stage_q[`STAGE_COUNT-2:0], fifo_out_bit};
      end else begin
        stage_d = {fifo_out_bit, stage_q[`STAGE_COUNT-1:1]};
      end
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      stage_q <= {`STAGE_COUNT{1'b0}};
    end else begin
      stage_q <= stage_d;
    end
  end

  // ----------------------------------------------------------------------
  // cascade and port direction
  // ----------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      serial_port_a_out <= 1'b0;
      serial_port_a_oe  <= 1'b0;
      serial_port_b_out <= 1'b0;
      serial_port_b_oe  <= 1'b0;
    end else begin
      serial_port_a_oe  <= ~dir_sync_q[1];
      serial_port_b_oe  <= dir_sync_q[1];
      serial_port_a_out <= stage_d[0];
      serial_port_b_out <= stage_d[`STAGE_LAST];
    end
  end

  // ----------------------------------------------------------------------
  // latches and output stage
  // ----------------------------------------------------------------------
  reg  [`STAGE_COUNT-1:0] latch_q;

  // physical position p follows stage p in both directions, so the
  // logical number of a position flips with the direction
  genvar i;
  generate
    for (i = 0; i < `STAGE_COUNT; i = i + 1) begin : g_out
      always @(posedge ref_clk) begin
        if (sys_rst) begin
          latch_q[i]         <= 1'b0;
          parallel_output[i] <= 1'b0;
        end else begin
          if (le_sync_q[1]) begin
            latch_q[i] <= stage_q[i];
          end
          if (!bl_sync_q[1]) begin
            parallel_output[i] <= ~pol_sync_q[1];
          end else begin
            parallel_output[i] <= latch_q[i] ^ ~pol_sync_q[1];
          end
        end
      end
    end
  endgenerate
  // latch_q keeps its value while latch enable is low

endmodule // sipo_driver

`default_nettype wire

// file: sipo_driver_bench.sv
/* self-checking bench for sipo_driver with a controller model.
   assumes panel_ctrl and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module sipo_driver_bench;
  logic ref_clk = 1'b0, sys_rst = 1'b1, shift_dir = 1'b0, start = 1'b0;
  logic latch_transparent = 1'b0, output_blank_n = 1'b1, slow = 1'b0;
  logic output_polarity = 1'b1, a_out, a_oe, b_out, b_oe, ca, cb, busy;
  logic shift_clk, capture_ready;
  logic [63:0] parallel_output, w, prev = 64'h0;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  sipo_driver dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .shift_clk(shift_clk), .shift_dir(shift_dir),
    .latch_transparent(latch_transparent), .output_blank_n(output_blank_n),
    .output_polarity(output_polarity), .serial_port_a_in(a_oe ? a_out : ca),
    .serial_port_a_out(a_out), .serial_port_a_oe(a_oe),
    .serial_port_b_in(b_oe ? b_out : cb), .serial_port_b_out(b_out),
    .serial_port_b_oe(b_oe), .parallel_output(parallel_output),
    .capture_ready(capture_ready));
  panel_ctrl ctl (.ref_clk(ref_clk), .start(start), .dir(shift_dir),
    .slow(slow), .word(w), .shift_clk(shift_clk), .data_a(ca),
    .data_b(cb), .busy(busy));
  initial forever #20 ref_clk = ~ref_clk;
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [63:0] exp_out(logic [63:0] l, logic b, logic p);
    return !b ? {64{!p}} : (p ? l : ~l);
  endfunction
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 9000) begin
      n_mismatch++;
      summarize();
    end
    if (busy) begin
      output_blank_n  <= 1'($urandom);
      output_polarity <= 1'($urandom);
    end
  end
  initial begin
    w = 64'($urandom(32'h860C2B13));
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 64'h8000_0000_0000_0001 : {$urandom, $urandom};
      shift_dir <= i[0];
      slow      <= 1'($urandom);
      repeat (6) @(posedge ref_clk);
      chk(64'({a_oe, b_oe}), 64'({!i[0], i[0]}));
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      wait (busy);
      wait (!busy);
      @(posedge ref_clk);
      output_blank_n  <= 1'b1;
      output_polarity <= i[1];
      repeat (10) @(posedge ref_clk);
      chk(parallel_output, exp_out(prev, 1'b1, i[1]));
      chk(64'({a_out, b_out}), 64'({w[0], w[63]}));
      latch_transparent <= 1'b1;
      repeat (10) @(posedge ref_clk);
      latch_transparent <= 1'b0;
      prev = w;
      for (int m = 0; m < 4; m++) begin
        output_blank_n  <= m[0];
        output_polarity <= m[1];
        repeat (8) @(posedge ref_clk);
        chk(parallel_output,
            exp_out(w, m[0], m[1]));
      end
    end
    summarize();
  end
endmodule // sipo_driver_bench
`default_nettype wire

// file: sipo_driver_map.vh
/*
  constants for the 64-stage serial to parallel driver: stage count,
  fifo depth and timing figures.
  assumes it is included by bare name from the design files.
*/
`ifndef SIPO_DRIVER_MAP_VH
`define SIPO_DRIVER_MAP_VH

// ----------------------------------------------------------------------
// structure
// ----------------------------------------------------------------------
`define STAGE_COUNT       64
`define STAGE_LAST        63
`define FIFO_WIDTH        1
`define FIFO_DEPTH        4
`define FIFO_ADDR_W       2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define REF_CLK_PERIOD_NS 40
`define SHIFT_CLK_MAX_KHZ 8000
`define SHIFT_CLK_MIN_PERIOD_NS (1000000 / `SHIFT_CLK_MAX_KHZ)
`define SHIFT_CLK_MIN_WIDTH_NS 62
`define SHIFT_CLK_MIN_WIDTH_CYC \
  ((`SHIFT_CLK_MIN_WIDTH_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
`define LATCH_DELAY_NS    25
`define LATCH_DELAY_CYC \
  ((`LATCH_DELAY_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

`endif

// file: sipo_driver_props.sv
/* port checker for sipo_driver.
   assumes only the top ports, attached by the bind at the foot. */
`timescale 1ns/1ps
`default_nettype none
module sipo_driver_props (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        shift_clk,
  input wire logic        shift_dir,
  input wire logic        latch_transparent,
  input wire logic        output_blank_n,
  input wire logic        output_polarity,
  input wire logic        serial_port_a_out,
  input wire logic        serial_port_a_oe,
  input wire logic        serial_port_b_out,
  input wire logic        serial_port_b_oe,
  input wire logic [63:0] parallel_output,
  input wire logic        capture_ready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  blank_level_a: assert property (
    (!output_blank_n && $stable(output_polarity))[*5]
    |-> parallel_output == {64{!output_polarity}}) else $error("blank");
  latch_hold_a: assert property (
    (!latch_transparent && $stable(output_blank_n)
     && $stable(output_polarity))[*6] |-> $stable(parallel_output))
    else $error("latch hold");
  port_enable_a: assert property (
    $stable(shift_dir)[*5] |-> serial_port_b_oe == shift_dir
    && serial_port_a_oe == !shift_dir) else $error("port enable");
  single_drive_a: assert property (
    !(serial_port_a_oe && serial_port_b_oe)) else $error("both driven");
  shift_quiet_a: assert property (
    $stable(shift_clk)[*8] |-> $stable(serial_port_a_out)
    && $stable(serial_port_b_out)) else $error("shift without clock");
  pass_through_a: assert property (
    (latch_transparent && output_blank_n && output_polarity
     && $stable(shift_clk))[*8] |-> parallel_output[63] == serial_port_b_out
    && parallel_output[0] == serial_port_a_out) else $error("pass");
  invert_out_a: assert property (
    (latch_transparent && output_blank_n && !output_polarity
     && $stable(shift_clk))[*8] |-> parallel_output[63] == !serial_port_b_out
    && parallel_output[0] == !serial_port_a_out) else $error("invert");
  fifo_ready_a: assert property (capture_ready) else $error("bit lost");
  reset_clear_a: assert property (disable iff (1'b0)
    sys_rst |=> parallel_output == 64'h0 && !serial_port_b_oe)
    else $error("reset");
  cover property (latch_transparent && !output_polarity);
  cover property ($rose(serial_port_b_oe));
  cover property (!output_blank_n && output_polarity);
endmodule // sipo_driver_props
bind sipo_driver sipo_driver_props chk_i (.ref_clk, .sys_rst, .shift_clk,
  .shift_dir, .latch_transparent, .output_blank_n, .output_polarity,
  .serial_port_a_out, .serial_port_a_oe, .serial_port_b_out,
  .serial_port_b_oe, .parallel_output, .capture_ready);
`default_nettype wire
